/* design/splc_lockstep.sv */
// Purpose: lock-step role control of one bus_interface_unit in a shadow pair
// Assumes: memory bus, arbitration and interconnect inputs are asynchronous
// Notes: apb answers one cycle after setup; bus pins are split into out/oe
`timescale 1ns/10ps

// Operation
// - marriage makes primary active, shadow passive
// - only active partner drives memory bus
// - passive partner tracks bus and arbitration
// - both capture incoming data, active sends
// - swap roles after every own request
// - self checks run whether active or passive
// - unmarry takes effect in both together
// - unmarried modules both become active, but an active one unmarried in its drive step goes passive
// - unmarried decode physical id, arbitrate logical
// - married decode uses shared logical id
// - shadow passive until primary first request
// - processor clear command pulses clear output
module splc_lockstep
  import splc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // processor side request
  input wire logic i_proc_req,
  input wire logic [DATA_W-1:0] i_proc_wdata,
  output logic o_proc_done,
  output logic [DATA_W-1:0] o_proc_rdata,
  output logic o_proc_clear,
  // memory bus and arbitration
  input wire logic i_arb_grant,
  input wire logic i_mbus_valid,
  input wire logic [DATA_W-1:0] i_mbus_data,
  input wire logic i_mbus_parity,
  output logic [DATA_W-1:0] o_mbus_data,
  output logic o_mbus_oe,
  output logic [ID_W-1:0] o_arb_id,
  output logic o_arb_oe,
  // interconnect register command from the bus
  input wire logic i_icr_valid,
  input wire logic [ID_W-1:0] i_icr_id,
  input wire logic [1:0] i_icr_cmd,
  // physical module id strap
  input wire logic [ID_W-1:0] i_phys_id
);

  // ==========================================================================
  // state
  typedef struct packed {
    // synchronisers, first stage read only by the second
    logic grant_s1;
    logic grant_s2;
    logic mvalid_s1;
    logic mvalid_s2;
    logic [DATA_W-1:0] mdata_s1;
    logic [DATA_W-1:0] mdata_s2;
    logic mpar_s1;
    logic mpar_s2;
    logic icr_valid_s1;
    logic icr_valid_s2;
    logic [ID_W-1:0] icr_id_s1;
    logic [ID_W-1:0] icr_id_s2;
    logic [1:0] icr_cmd_s1;
    logic [1:0] icr_cmd_s2;
    logic [ID_W-1:0] phys_s1;
    logic [ID_W-1:0] phys_s2;
    // configuration
    logic married;
    logic shadow;
    logic [ID_W-1:0] logical_id;
    logic [ID_W-1:0] proc_id;
    logic [ID_W-1:0] spouse_id;
    // role and status
    logic active;
    logic error;
    splc_seq_type seq;
    logic [3:0] clr_cnt;
    // outputs
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic proc_done;
    logic [DATA_W-1:0] proc_rdata;
    logic proc_clear;
    logic [DATA_W-1:0] mbus_data;
    logic mbus_oe;
    logic [ID_W-1:0] arb_id;
    logic arb_oe;
  } splc_state_type;

  splc_state_type r;
  splc_state_type next_r;

  // ==========================================================================
  // address decode shared by read mux and error answer
  function automatic logic splc_mapped(input logic [31:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr[31:8] != 24'h00_0000) begin
      hit = 1'b0;
    end else if (addr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (addr[7:0] <= OFF_STATUS) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // ==========================================================================
  // combinational next state
  always_comb begin
    logic apb_wr;
    logic icr_hit;
    logic [ID_W-1:0] match_id;
    logic unmarry;
    logic clear_cmd;
    logic married_w;
    logic shadow_w;
    logic [7:0] off;
    apb_wr = 1'b0;
    icr_hit = 1'b0;
    match_id = '0;
    unmarry = 1'b0;
    clear_cmd = 1'b0;
    married_w = 1'b0;
    shadow_w = 1'b0;
    off = i_paddr[7:0];
    next_r = r;

    // two-flop synchronisers for everything arriving from the bus pins
    next_r.grant_s1 = i_arb_grant;
    next_r.grant_s2 = r.grant_s1;
    next_r.mvalid_s1 = i_mbus_valid;
    next_r.mvalid_s2 = r.mvalid_s1;
    next_r.mdata_s1 = i_mbus_data;
    next_r.mdata_s2 = r.mdata_s1;
    next_r.mpar_s1 = i_mbus_parity;
    next_r.mpar_s2 = r.mpar_s1;
    next_r.icr_valid_s1 = i_icr_valid;
    next_r.icr_valid_s2 = r.icr_valid_s1;
    next_r.icr_id_s1 = i_icr_id;
    next_r.icr_id_s2 = r.icr_id_s1;
    next_r.icr_cmd_s1 = i_icr_cmd;
    next_r.icr_cmd_s2 = r.icr_cmd_s1;
    next_r.phys_s1 = i_phys_id;
    next_r.phys_s2 = r.phys_s1;

    // interconnect decode: shared logical id while married, own id after
    match_id = r.married ? r.logical_id : r.phys_s2;
    icr_hit = r.icr_valid_s2 && (r.icr_id_s2 == match_id);
    // the unmarry command reaches both partners through the same id
    unmarry = icr_hit && (r.icr_cmd_s2 == ICR_CMD_UNMARRY);
    clear_cmd = icr_hit && (r.icr_cmd_s2 == ICR_CMD_CLEAR_PU);

    // ------------------------------------------------------------------------
    // apb: ready comes one cycle after setup, so every access is two cycles
    next_r.pready = i_psel && !i_penable && !r.pready;
    apb_wr = i_psel && i_penable && r.pready && i_pwrite && splc_mapped(i_paddr);
    // the error answer stands only with pready, never into the next cycle
    next_r.pslverr = 1'b0;
    if (i_psel && !i_penable) begin
      next_r.pslverr = !splc_mapped(i_paddr);
      next_r.prdata = 32'h0000_0000;
      if (!i_pwrite && splc_mapped(i_paddr)) begin
        if (off == OFF_STATE) begin
          next_r.prdata[BIT_MARRIED] = r.married;
          next_r.prdata[BIT_SHADOW] = r.shadow;
        end else if (off == OFF_LOGICAL_ID) begin
          next_r.prdata[ID_W-1:0] = r.logical_id;
        end else if (off == OFF_PROC_ID) begin
          next_r.prdata[ID_W-1:0] = r.proc_id;
        end else if (off == OFF_PHYS_ID) begin
          next_r.prdata[ID_W-1:0] = r.phys_s2;
        end else if (off == OFF_SPOUSE_ID) begin
          next_r.prdata[ID_W-1:0] = r.spouse_id;
        end else if (off == OFF_STATUS) begin
          next_r.prdata[BIT_ST_ACTIVE] = r.active;
          next_r.prdata[BIT_ST_ERROR] = r.error;
          next_r.prdata[BIT_ST_BUSY] = (r.seq != SPLC_IDLE);
        end
      end
    end

    // ------------------------------------------------------------------------
    // register writes; the state register also sets the role flag
    married_w = i_pwdata[BIT_MARRIED];
    shadow_w = i_pwdata[BIT_SHADOW];
    if (apb_wr) begin
      if (off == OFF_STATE) begin
        next_r.married = married_w;
        next_r.shadow = shadow_w;
        if (married_w && !r.married) begin
          // shadow waits passive for the primary's first request
          next_r.active = !shadow_w;
        end else if (!married_w) begin
          next_r.active = 1'b1;
        end
      end else if (off == OFF_LOGICAL_ID) begin
        next_r.logical_id = i_pwdata[ID_W-1:0];
      end else if (off == OFF_PROC_ID) begin
        next_r.proc_id = i_pwdata[ID_W-1:0];
      end else if (off == OFF_SPOUSE_ID) begin
        next_r.spouse_id = i_pwdata[ID_W-1:0];
      end else if (off == OFF_CLEAR_PU) begin
        clear_cmd = 1'b1;
      end
    end

    // a bus unmarry clears the bit in the same cycle in both partners
    if (unmarry) begin
      next_r.married = 1'b0;
      next_r.active = 1'b1;
    end

    // ------------------------------------------------------------------------
    // processor clear pulse of fixed width, retriggered by a new command
    if (clear_cmd) begin
      next_r.clr_cnt = CLEAR_PU_CNT;
    end else if (r.clr_cnt != 4'h0) begin
      next_r.clr_cnt = r.clr_cnt - 4'h1;
    end
    next_r.proc_clear = clear_cmd || (r.clr_cnt > 4'h1);

    // ------------------------------------------------------------------------
    // incoming data is taken regardless of role
    if (r.mvalid_s2) begin
      next_r.proc_rdata = r.mdata_s2;
    end

    // self check on incoming parity keeps running while passive too;
    // a new error wins over a software clear in the same cycle
    if (apb_wr && off == OFF_STATUS && i_pwdata[BIT_ST_ERROR]) begin
      next_r.error = 1'b0;
    end
    if (r.mvalid_s2 && ((^r.mdata_s2) != r.mpar_s2)) begin
      next_r.error = 1'b1;
    end

    // ------------------------------------------------------------------------
    // request sequencer: both partners step through it on the same grant
    next_r.proc_done = 1'b0;
    next_r.mbus_oe = 1'b0;
    next_r.arb_oe = 1'b0;
    next_r.arb_id = r.logical_id;
    case (r.seq)
      SPLC_IDLE: begin
        if (i_proc_req) begin
          next_r.seq = SPLC_WAIT;
          next_r.arb_oe = r.active;
        end
      end
      SPLC_WAIT: begin
        // passive partner watches the same grant to stay in step
        next_r.arb_oe = r.active;
        if (r.grant_s2) begin
          next_r.seq = SPLC_DRIVE;
          next_r.arb_oe = 1'b0;
          next_r.mbus_oe = r.active;
          next_r.mbus_data = r.active ? i_proc_wdata : 32'h0000_0000;
        end
      end
      SPLC_DRIVE: begin
        next_r.seq = SPLC_DONE;
        next_r.proc_done = 1'b1;
        // ping-pong: the partner that just waited drives next time
        if (r.married) begin
          next_r.active = !r.active;
        end
      end
      SPLC_DONE: begin
        if (!i_proc_req) begin
          next_r.seq = SPLC_IDLE;
        end
      end
      default: begin
        next_r.seq = SPLC_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // state register; unmarried and active out of reset
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
      r.active <= 1'b1;
      r.logical_id <= RST_LOGICAL_ID;
      r.proc_id <= RST_PROC_ID;
      r.spouse_id <= RST_SPOUSE_ID;
      r.seq <= SPLC_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // outputs, all straight from the state register
  assign o_prdata = r.prdata;
  assign o_pready = r.pready;
  assign o_pslverr = r.pslverr;
  assign o_proc_done = r.proc_done;
  assign o_proc_rdata = r.proc_rdata;
  assign o_proc_clear = r.proc_clear;
  assign o_mbus_data = r.mbus_data;
  assign o_mbus_oe = r.mbus_oe;
  assign o_arb_id = r.arb_id;
  assign o_arb_oe = r.arb_oe;

endmodule

/* design/splc_pkg.sv */
// Purpose: shared constants and types for the shadow pair lock-step control
// Assumes: 40 MHz system clock, APB register access with 32-bit data
// Notes: register offsets are byte addresses, one aligned word per register
package splc_pkg;

  // =========================================================================
  // widths
  localparam int ID_W = 8;
  localparam int DATA_W = 32;

  // =========================================================================
  // register byte offsets
  localparam logic [7:0] OFF_STATE = 8'h00;
  localparam logic [7:0] OFF_LOGICAL_ID = 8'h04;
  localparam logic [7:0] OFF_PROC_ID = 8'h08;
  localparam logic [7:0] OFF_PHYS_ID = 8'h0C;
  localparam logic [7:0] OFF_SPOUSE_ID = 8'h10;
  localparam logic [7:0] OFF_CLEAR_PU = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // =========================================================================
  // field positions
  localparam int BIT_MARRIED = 0;
  localparam int BIT_SHADOW = 1;
  localparam int BIT_ST_ACTIVE = 0;
  localparam int BIT_ST_ERROR = 1;
  localparam int BIT_ST_BUSY = 2;

  // =========================================================================
  // reset values
  localparam logic [ID_W-1:0] RST_LOGICAL_ID = 8'h00;
  localparam logic [ID_W-1:0] RST_PROC_ID = 8'h00;
  localparam logic [ID_W-1:0] RST_SPOUSE_ID = 8'h00;

  // =========================================================================
  // interconnect commands seen on the memory bus
  localparam logic [1:0] ICR_CMD_NONE = 2'h0;
  localparam logic [1:0] ICR_CMD_CLEAR_PU = 2'h1;
  localparam logic [1:0] ICR_CMD_UNMARRY = 2'h2;

  // =========================================================================
  // timing: processor clear pulse width
  localparam int CLK_PERIOD_PS = 25000;
  localparam int CLEAR_PU_NS = 100;
  localparam int CLEAR_PU_CYC = (CLEAR_PU_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] CLEAR_PU_CNT = 4'(CLEAR_PU_CYC);

  // =========================================================================
  // request sequencer, gray coded along the usual path
  typedef enum logic [1:0] {
    SPLC_IDLE = 2'b00,
    SPLC_WAIT = 2'b01,
    SPLC_DRIVE = 2'b11,
    SPLC_DONE = 2'b10
  } splc_seq_type;

endpackage

/* tb/splc_lockstep_assertions.sv */
// Purpose: port assertions for splc_lockstep
// Assumes: one clock, async active-low reset
// Notes: bound to the design at the foot of this file
`timescale 1ns/10ps
module splc_chk (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_proc_req,
  input wire logic i_arb_grant,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_proc_done,
  input wire logic o_proc_clear,
  input wire logic o_mbus_oe,
  input wire logic o_arb_oe
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);
  // ==========
  // apb answers one cycle after setup
  chk_apb_ready: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no pready after setup");
  chk_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  chk_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready too long");
  // ==========
  // only a granted, active partner drives, then completes
  chk_drive_excl: assert property (o_mbus_oe |-> !o_arb_oe && i_proc_req)
    else $error("bus driven outside a request");
  chk_drive_done: assert property (o_mbus_oe |=> o_proc_done && !o_mbus_oe)
    else $error("no done after drive");
  chk_grant_drive: assert property (o_arb_oe && i_arb_grant |-> ##[1:4] o_mbus_oe)
    else $error("grant not followed by drive");
  chk_done_pulse: assert property (o_proc_done |=> !o_proc_done)
    else $error("done too long");
  // clear must be long enough for the processor to settle
  chk_clear_width: assert property ($rose(o_proc_clear) |->
    o_proc_clear[*4] ##1 !o_proc_clear)
    else $error("clear width wrong");
endmodule

bind splc_lockstep splc_chk i_chk (
  .i_sys_clk(i_sys_clk),
  .i_reset_n(i_reset_n),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .i_proc_req(i_proc_req),
  .i_arb_grant(i_arb_grant),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .o_proc_done(o_proc_done),
  .o_proc_clear(o_proc_clear),
  .o_mbus_oe(o_mbus_oe),
  .o_arb_oe(o_arb_oe)
);

/* tb/splc_bus_model.sv */
// Purpose: memory bus and arbitration seen by one partner
// Assumes: grant follows any arbitration under the shared id
// Notes: idle data lines show the inverted last word
`timescale 1ns/10ps
module splc_bus_model (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_arb_req,
  input wire logic i_peer_req,
  input wire logic i_send,
  input wire logic i_bad_par,
  input wire logic [31:0] i_word,
  output logic o_grant,
  output logic o_valid,
  output logic [31:0] o_data,
  output logic o_parity
);
  logic [31:0] last;
  // ==========
  // grant and incoming words; idle lines never hold a stale word
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_grant <= 1'h0;
      o_valid <= 1'h0;
      o_data <= 32'h0000_0000;
      o_parity <= 1'h0;
      last <= 32'h0000_0000;
    end else begin
      o_grant <= i_arb_req | i_peer_req;
      o_valid <= i_send;
      last <= i_send ? i_word : last;
      o_data <= i_send ? i_word : ~last;
      o_parity <= i_send ? (^i_word) ^ i_bad_par : !o_parity;
    end
  end
endmodule

/* tb/testbench.sv */
// Purpose: self-checking bench for splc_lockstep
// Assumes: bus model stands for the memory bus side
// Notes: role expected from a small integer model
`timescale 1ns/10ps
module testbench;
  import splc_pkg::*;
  logic i_sys_clk, i_reset_n, i_psel, i_penable, i_pwrite, i_proc_req, i_arb_grant;
  logic i_mbus_valid, i_mbus_parity, i_icr_valid, o_pready, o_pslverr, o_proc_done;
  logic o_proc_clear, o_mbus_oe, o_arb_oe, peer_req, send, bad_par, er;
  logic [31:0] i_paddr, i_pwdata, o_prdata, i_proc_wdata, o_proc_rdata;
  logic [31:0] i_mbus_data, o_mbus_data, word, rd;
  logic [7:0] o_arb_id, i_icr_id, i_phys_id, lid;
  logic [1:0] i_icr_cmd;
  int fail_count, total_checks, act, mar, clr_n;
  splc_lockstep i_dut (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_proc_req(i_proc_req), .i_proc_wdata(i_proc_wdata),
    .o_proc_done(o_proc_done), .o_proc_rdata(o_proc_rdata),
    .o_proc_clear(o_proc_clear), .i_arb_grant(i_arb_grant),
    .i_mbus_valid(i_mbus_valid), .i_mbus_data(i_mbus_data),
    .i_mbus_parity(i_mbus_parity), .o_mbus_data(o_mbus_data),
    .o_mbus_oe(o_mbus_oe), .o_arb_id(o_arb_id), .o_arb_oe(o_arb_oe),
    .i_icr_valid(i_icr_valid), .i_icr_id(i_icr_id), .i_icr_cmd(i_icr_cmd),
    .i_phys_id(i_phys_id));
  splc_bus_model i_bus (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_arb_req(o_arb_oe),
    .i_peer_req(peer_req), .i_send(send), .i_bad_par(bad_par), .i_word(word),
    .o_grant(i_arb_grant), .o_valid(i_mbus_valid), .o_data(i_mbus_data),
    .o_parity(i_mbus_parity));
  // ==========
  // clock and clear-cycle counter
  initial begin
    i_sys_clk = 1'h0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    if (o_proc_clear === 1'h1) clr_n++;
  end
  // ==========
  // compare, verdict and hang guard
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic hang(input logic bad);
    if (bad) begin
      fail_count++;
      finish_test();
    end
  endtask
  // apb master; one idle edge keeps drivers from double assignment
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1'h1;
    i_penable <= 1'h0;
    i_pwrite <= w;
    i_paddr <= {24'h00_0000, a};
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'h1;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_pready !== 1'h1 && n < 20);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    hang(o_pready !== 1'h1);
    @(posedge i_sys_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0000_0000);
    chk("read", rd, exp);
  endtask
  // processor request; a passive partner sees the spouse win the grant
  task automatic req();
    int n, oe, arb;
    n = 0;
    oe = 0;
    arb = 0;
    i_proc_req <= 1'h1;
    i_proc_wdata <= $urandom;
    peer_req <= (act == 0);
    do begin
      @(posedge i_sys_clk);
      n++;
      if (o_arb_oe === 1'h1) arb++;
      if (o_mbus_oe === 1'h1) begin
        oe++;
        chk("mdata", o_mbus_data, i_proc_wdata);
      end
    end while (o_proc_done !== 1'h1 && n < 40);
    hang(o_proc_done !== 1'h1);
    chk("drive", 32'(oe), 32'(act));
    chk("arb", 32'(arb != 0), 32'(act));
    if (mar != 0) act = 1 - act;
    i_proc_req <= 1'h0;
    peer_req <= 1'h0;
    repeat (5) @(posedge i_sys_clk);
  endtask
  task automatic snd(input logic bad);
    word <= $urandom;
    send <= 1'h1;
    bad_par <= bad;
    @(posedge i_sys_clk);
    send <= 1'h0;
    repeat (6) @(posedge i_sys_clk);
    if (!bad) chk("rdata", o_proc_rdata, word);
  endtask
  task automatic icr(input logic [7:0] id, input logic [1:0] c, input int exp);
    clr_n = 0;
    i_icr_valid <= 1'h1;
    i_icr_id <= id;
    i_icr_cmd <= c;
    @(posedge i_sys_clk);
    i_icr_valid <= 1'h0;
    repeat (10) @(posedge i_sys_clk);
    chk("clear", 32'(clr_n), 32'(exp));
  endtask
  // ==========
  // main sequence
  initial begin
    void'($urandom(32'h0471_4bfd));
    {fail_count, total_checks, mar, clr_n} = '0;
    act = 1;
    {i_psel, i_penable, i_pwrite, i_proc_req, i_icr_valid, peer_req, send, bad_par} = '0;
    {i_paddr, i_pwdata, i_proc_wdata, word, i_icr_id, i_icr_cmd} = '0;
    i_phys_id = 8'($urandom);
    lid = i_phys_id ^ 8'h01;
    i_reset_n = 1'h0;
    repeat (3) @(posedge i_sys_clk);
    i_reset_n <= 1'h1;
    repeat (2) @(posedge i_sys_clk);
    rdc(OFF_STATE, 32'h0000_0000);
    rdc(OFF_STATUS, 32'h0000_0001);
    apb(1'h1, OFF_PHYS_ID, 32'h0000_00FF);
    rdc(OFF_PHYS_ID, {24'h00_0000, i_phys_id});
    apb(1'h0, 8'h1C, 32'h0000_0000);
    chk("slverr", {31'h0, er}, 32'h0000_0001);
    apb(1'h1, OFF_PROC_ID, 32'h0000_00A5);
    rdc(OFF_PROC_ID, 32'h0000_00A5);
    // spouse register holds the partner's physical id
    apb(1'h1, OFF_SPOUSE_ID, {24'h00_0000, lid});
    rdc(OFF_SPOUSE_ID, {24'h00_0000, lid});
    $display("test regs done");
    // primary marriage, ping-pong, self-check while passive
    apb(1'h1, OFF_LOGICAL_ID, {24'h00_0000, lid});
    apb(1'h1, OFF_STATE, 32'h0000_0001);
    mar = 1;
    rdc(OFF_STATUS, 32'(act));
    for (int i = 0; i < 3; i++) begin
      req();
      rdc(OFF_STATUS, 32'(act));
      snd(1'h0);
    end
    icr(lid, ICR_CMD_CLEAR_PU, CLEAR_PU_CYC);
    icr(i_phys_id, ICR_CMD_CLEAR_PU, 0);
    snd(1'h1);
    rdc(OFF_STATUS, 32'h0000_0002);
    apb(1'h1, OFF_STATUS, 32'h0000_0002);
    rdc(OFF_STATUS, 32'h0000_0000);
    $display("test primary done");
    // split by interconnect command under the shared id
    // no request is outstanding here: the last req has completed before the split
    icr(lid, ICR_CMD_UNMARRY, 0);
    mar = 0;
    act = 1;
    rdc(OFF_STATE, 32'h0000_0000);
    req();
    rdc(OFF_STATUS, 32'h0000_0001);
    icr(i_phys_id, ICR_CMD_CLEAR_PU, CLEAR_PU_CYC);
    icr(lid, ICR_CMD_CLEAR_PU, 0);
    chk("arb_id", {24'h00_0000, o_arb_id}, {24'h00_0000, lid});
    // new processor id for the split module, read back as at start-up
    apb(1'h1, OFF_PROC_ID, {24'h00_0000, lid});
    rdc(OFF_PROC_ID, {24'h00_0000, lid});
    $display("test unmarry done");
    // shadow stays passive until the first request
    apb(1'h1, OFF_STATE, 32'h0000_0002);
    apb(1'h1, OFF_STATE, 32'h0000_0003);
    mar = 1;
    act = 0;
    rdc(OFF_STATUS, 32'h0000_0000);
    req();
    rdc(OFF_STATUS, 32'h0000_0001);
    req();
    clr_n = 0;
    apb(1'h1, OFF_CLEAR_PU, $urandom);
    repeat (8) @(posedge i_sys_clk);
    chk("clear", 32'(clr_n), 32'(CLEAR_PU_CYC));
    apb(1'h1, OFF_STATE, 32'h0000_0000);
    rdc(OFF_STATE, 32'h0000_0000);
    rdc(OFF_STATUS, 32'h0000_0001);
    $display("test shadow done");
    finish_test();
  end
endmodule
